// ---- verilog/mas_sequencer.v ----
`timescale 1ns/10ps
`include "mas_map.vh"
module mas_sequencer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire power_detected,
    input wire trigger_input_pin,
    input wire conv_done,
    input wire [9:0] conv_data,
    output reg conv_start,
    output reg [2:0] mux_select,
    output reg full_scale_high,
    output reg internal_ref_en,
    output reg [1:0] bias_one_sel,
    output reg [1:0] bias_two_sel,
    output reg thermistor_bias_en,
    output reg input_one_bias_en,
    output reg int_n
);
    localparam S_IDLE = 5'b00001;
    localparam S_ARM = 5'b00010;
    localparam S_DELAY = 5'b00100;
    localparam S_CONV = 5'b01000;
    localparam S_WAIT = 5'b10000;

    reg [31:0] setup_q;
    reg [31:0] delay_q;
    reg [31:0] wait_q;
    reg [1:0] rsel_q;
    reg int_mask_q;
    reg done_q;
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [15:0] tmr_q;
    reg [8:0] left_q;
    reg [18:0] sum_q;
    reg [9:0] min_q;
    reg [9:0] max_q;
    reg [9:0] last_q;
    reg [10:0] res_avg_q;
    reg [9:0] res_min_q;
    reg [9:0] res_max_q;
    reg [9:0] res_last_q;
    reg en_q;
    reg trg_q;
    reg [3:0] shift_q;

    wire wr = psel && penable && pwrite;
    wire busy = (state_q != S_IDLE);
    wire ext_mode = delay_q[`MAS_EXTTRG_BIT];
    wire edge_rise = delay_q[`MAS_EDGE_BIT];
    wire trg_active = edge_rise ? trigger_input_pin : !trigger_input_pin;
    wire trg_edge = edge_rise ? (trigger_input_pin && !trg_q) : (!trigger_input_pin && trg_q);
    wire en_now = setup_q[`MAS_EN_BIT];
    wire en_rise = en_now && !en_q;
    wire [2:0] cnt_code = setup_q[`MAS_CNT_LSB +: 3];
    wire last_sample = (left_q == 9'h001);
    wire [3:0] dly_code = delay_q[`MAS_DLY_LSB +: 4];
    wire [2:0] wait_code = wait_q[`MAS_WAIT_LSB +: 3];
    wire [18:0] sum_next = sum_q + {9'h000, conv_data};
    // full-width shift, the average itself never needs more than 11 bits
    wire [18:0] avg_full = sum_next >> shift_q;
    // largest delay and wait codes still fit the 16-bit timer
    wire [31:0] dly_cyc = {28'h0000000, dly_code} * `MAS_DLY_STEP_CYC;
    wire [31:0] wait_cyc = (32'h00000001 << wait_code) * `MAS_WAIT_UNIT_CYC;

    // sample count 1,4,8..256 as a shift
    function [8:0] count_of;
        input [2:0] c;
        begin
            count_of = (c == 3'h0) ? 9'h001 : (9'h002 << c);
        end
    endfunction

    function [3:0] shift_of;
        input [2:0] c;
        begin
            shift_of = (c == 3'h0) ? 4'h0 : ({1'b0, c} + 4'h1);
        end
    endfunction

    function [10:0] pick;
        input [1:0] s;
        begin
            case (s)
                `MAS_RD_AVG: pick = res_avg_q;
                `MAS_RD_MIN: pick = {1'b0, res_min_q};
                `MAS_RD_MAX: pick = {1'b0, res_max_q};
                default: pick = {1'b0, res_last_q};
            endcase
        end
    endfunction

    // fsm
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (en_rise)
                    state_d = ext_mode ? S_ARM : S_DELAY;
            S_ARM:
                if (trg_edge)
                    state_d = S_DELAY;
            S_DELAY:
                if (tmr_q == 16'h0000)
                    state_d = (!ext_mode || trg_active) ? S_CONV : S_ARM;
            S_CONV:
                if (conv_done)
                    state_d = last_sample ? (setup_q[`MAS_REPEAT_BIT] ? S_WAIT : S_IDLE) : S_WAIT;
            S_WAIT:
                if (tmr_q == 16'h0000)
                begin
                    // holdoff: later samples need the trigger still active
                    if (ext_mode && delay_q[`MAS_HOLDOFF_BIT] && !trg_active)
                        state_d = S_ARM;
                    else
                        state_d = S_CONV;
                end
            default: state_d = S_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            tmr_q <= 16'h0000;
            left_q <= 9'h000;
            sum_q <= 19'h00000;
            min_q <= 10'h3FF;
            max_q <= 10'h000;
            last_q <= 10'h000;
            res_avg_q <= 11'h000;
            res_min_q <= 10'h000;
            res_max_q <= 10'h000;
            res_last_q <= 10'h000;
            done_q <= 1'b0;
            en_q <= 1'b0;
            trg_q <= 1'b0;
            shift_q <= 4'h0;
            conv_start <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            en_q <= en_now;
            trg_q <= trigger_input_pin;
            conv_start <= 1'b0;
            if (tmr_q != 16'h0000)
                tmr_q <= tmr_q - 16'h0001;
            if (state_q == S_IDLE && en_rise)
            begin
                left_q <= count_of(cnt_code);
                shift_q <= shift_of(cnt_code);
                sum_q <= 19'h00000;
                min_q <= 10'h3FF;
                max_q <= 10'h000;
                done_q <= 1'b0;
                tmr_q <= 16'h0000;
            end
            if (state_q == S_ARM && trg_edge)
                tmr_q <= dly_cyc[15:0];
            if (state_d == S_CONV && state_q != S_CONV)
                conv_start <= 1'b1;
            if (state_q == S_CONV && conv_done)
            begin
                // word handed to the arithmetic unit
                last_q <= conv_data;
                sum_q <= sum_next;
                if (conv_data < min_q)
                    min_q <= conv_data;
                if (conv_data > max_q)
                    max_q <= conv_data;
                left_q <= left_q - 9'h001;
                tmr_q <= wait_cyc[15:0];
                if (last_sample)
                begin
                    // cycle end: copy all four results
                    res_avg_q <= avg_full[10:0];
                    res_min_q <= (conv_data < min_q) ? conv_data : min_q;
                    res_max_q <= (conv_data > max_q) ? conv_data : max_q;
                    res_last_q <= conv_data;
                    done_q <= 1'b1;
                    if (setup_q[`MAS_REPEAT_BIT])
                    begin
                        left_q <= count_of(cnt_code);
                        sum_q <= 19'h00000;
                        min_q <= 10'h3FF;
                        max_q <= 10'h000;
                    end
                end
            end
        end
    end

    // apb slave, zero wait, host-only access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setup_q <= `MAS_SETUP_RST;
            delay_q <= `MAS_DELAY_RST;
            wait_q <= `MAS_WAIT_RST;
            rsel_q <= 2'b00;
            int_mask_q <= 1'b1;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                case (paddr)
                    `MAS_SETUP_OFF: prdata <= setup_q;
                    `MAS_DELAY_OFF: prdata <= delay_q;
                    `MAS_WAIT_OFF: prdata <= wait_q;
                    `MAS_READ_OFF: prdata <= {19'h00000, rsel_q, pick(rsel_q)};
                    `MAS_STAT_OFF: prdata <= {30'h00000000, int_mask_q, !done_q};
                    default: prdata <= 32'h00000000;
                endcase
                pslverr <= !(paddr == `MAS_SETUP_OFF || paddr == `MAS_DELAY_OFF ||
                    paddr == `MAS_WAIT_OFF || paddr == `MAS_READ_OFF ||
                    paddr == `MAS_STAT_OFF);
            end
            if (wr && pready)
            begin
                case (paddr)
                    // setup, delay and read select frozen while a cycle runs, enable bit excepted; wait always written
                    `MAS_SETUP_OFF:
                        if (busy)
                            setup_q[`MAS_EN_BIT] <= pwdata[`MAS_EN_BIT];
                        else
                            setup_q <= {23'h000000, pwdata[8:0]};
                    `MAS_DELAY_OFF: if (!busy) delay_q <= {25'h0000000, pwdata[6:0]};
                    `MAS_WAIT_OFF: wait_q <= {24'h000000, pwdata[7:0]};
                    `MAS_READ_OFF: if (!busy) rsel_q <= pwdata[`MAS_RSEL_LSB +: 2];
                    `MAS_STAT_OFF: int_mask_q <= pwdata[1];
                    default: int_mask_q <= int_mask_q;
                endcase
            end
        end
    end

    // analog side controls
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_select <= 3'h0;
            full_scale_high <= 1'b0;
            internal_ref_en <= 1'b1;
            bias_one_sel <= 2'b00;
            bias_two_sel <= 2'b00;
            thermistor_bias_en <= 1'b0;
            input_one_bias_en <= 1'b0;
            int_n <= 1'b1;
        end
        else
        begin
            mux_select <= setup_q[`MAS_CHSEL_LSB +: 3];
            full_scale_high <= (setup_q[`MAS_CHSEL_LSB +: 3] >= 3'h5);
            internal_ref_en <= !setup_q[`MAS_REFSEL_BIT];
            bias_one_sel <= wait_q[`MAS_BIAS1_LSB +: 2];
            bias_two_sel <= wait_q[`MAS_BIAS2_LSB +: 2];
            thermistor_bias_en <= power_detected;
            input_one_bias_en <= power_detected;
            // repeat mode never signals done on int_n
            int_n <= !(done_q && !int_mask_q && !setup_q[`MAS_REPEAT_BIT]);
        end
    end
endmodule // mas_sequencer

// ---- verilog/mas_map.vh ----
`ifndef MAS_MAP_VH
`define MAS_MAP_VH
// register byte offsets on the apb side
`define MAS_SETUP_OFF 12'h000
`define MAS_DELAY_OFF 12'h004
`define MAS_WAIT_OFF 12'h008
`define MAS_READ_OFF 12'h00C
`define MAS_STAT_OFF 12'h010
// setup register fields
`define MAS_CHSEL_LSB 0
`define MAS_REFSEL_BIT 3
`define MAS_EN_BIT 4
`define MAS_CNT_LSB 5
`define MAS_REPEAT_BIT 8
// delay register fields
`define MAS_DLY_LSB 0
`define MAS_EDGE_BIT 4
`define MAS_HOLDOFF_BIT 5
`define MAS_EXTTRG_BIT 6
// wait register fields
`define MAS_WAIT_LSB 0
`define MAS_BIAS1_LSB 4
`define MAS_BIAS2_LSB 6
// read register fields
`define MAS_RSEL_LSB 0
// reset values
`define MAS_SETUP_RST 32'h00000000
`define MAS_DELAY_RST 32'h00000000
`define MAS_WAIT_RST 32'h00000000
// timing: delay step 50 us, wait unit 20 us, at 25 MHz
`define MAS_CLK_MHZ 25
`define MAS_DLY_STEP_US 50
`define MAS_WAIT_UNIT_US 20
`define MAS_DLY_STEP_CYC (`MAS_DLY_STEP_US * `MAS_CLK_MHZ)
`define MAS_WAIT_UNIT_CYC (`MAS_WAIT_UNIT_US * `MAS_CLK_MHZ)
// read select codes
`define MAS_RD_AVG 2'b00
`define MAS_RD_MIN 2'b01
`define MAS_RD_MAX 2'b10
`define MAS_RD_LAST 2'b11
`endif

// ---- dv/mas_monitor.sv ----
`timescale 1ns/10ps
`include "mas_map.vh"
module mas_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire power_detected,
    input wire conv_done,
    input wire conv_start,
    input wire [2:0] mux_select,
    input wire full_scale_high,
    input wire internal_ref_en,
    input wire thermistor_bias_en,
    input wire input_one_bias_en,
    input wire int_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg done_q;
    wire set_wr = psel && penable && pwrite && pready && paddr == `MAS_SETUP_OFF;
    // a sample came back since the last start
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            done_q <= 1'b0;
        else if (conv_start || conv_done)
            done_q <= conv_done;
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready not one access cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_bias; power_detected |=> thermistor_bias_en && input_one_bias_en; endproperty
    a_bias: assert property (p_bias) else $error("bias sources off with power");
    property p_scale; full_scale_high == (mux_select > 3'h4); endproperty
    a_scale: assert property (p_scale) else $error("full scale group wrong");
    property p_start; conv_start |=> !conv_start; endproperty
    a_start: assert property (p_start) else $error("start not a pulse");
    property p_wait; conv_done |=> !conv_start [*8]; endproperty
    a_wait: assert property (p_wait) else $error("start too soon after sample");
    property p_int; $fell(int_n) |-> done_q; endproperty
    a_int: assert property (p_int) else $error("interrupt without sample");
    property p_ref; $changed(internal_ref_en) |-> $past(set_wr, 2); endproperty
    a_ref: assert property (p_ref) else $error("reference enable moved alone");
endmodule // mas_monitor
bind mas_sequencer mas_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .power_detected(power_detected), .conv_done(conv_done), .conv_start(conv_start),
    .mux_select(mux_select), .full_scale_high(full_scale_high),
    .internal_ref_en(internal_ref_en), .thermistor_bias_en(thermistor_bias_en),
    .input_one_bias_en(input_one_bias_en), .int_n(int_n));

// ---- dv/mas_conv_model.sv ----
`timescale 1ns/10ps
module mas_conv_model (
    input wire pclk,
    input wire presetn,
    input wire conv_start,
    input wire slow,
    input wire [9:0] sample_value,
    output reg conv_done,
    output reg [9:0] conv_data
);
    reg [3:0] cnt_q;
    // data is only valid with done; elsewhere it flips so nothing latches stale
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 10'h000;
        end
        else
        begin
            cnt_q <= conv_start ? (slow ? 4'h6 : 4'h1) : cnt_q - {3'h0, |cnt_q};
            conv_done <= cnt_q == 4'h1;
            conv_data <= (cnt_q == 4'h1) ? sample_value : ~conv_data;
        end
endmodule // mas_conv_model

// ---- dv/mas_sequencer_tb.sv ----
`timescale 1ns/10ps
`include "mas_map.vh"
module mas_sequencer_tb;
    reg pclk, presetn, psel, penable, pwrite, pwr, trig, slow, e;
    reg [11:0] paddr;
    reg [31:0] pwdata, q;
    reg [9:0] smp;
    wire [31:0] prdata;
    wire pready, pslverr, cdone, cstart, fs, iref, th_en, a1_en, int_n;
    wire [9:0] cdata;
    wire [2:0] mux;
    wire [1:0] b1, b2;
    integer n_errors, comparisons, n_start;
    mas_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_detected(pwr), .trigger_input_pin(trig), .conv_done(cdone),
        .conv_data(cdata), .conv_start(cstart), .mux_select(mux), .full_scale_high(fs),
        .internal_ref_en(iref), .bias_one_sel(b1), .bias_two_sel(b2),
        .thermistor_bias_en(th_en), .input_one_bias_en(a1_en), .int_n(int_n));
    mas_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_start(cstart), .slow(slow),
        .sample_value(smp), .conv_done(cdone), .conv_data(cdata));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (cstart === 1'b1)
            n_start = n_start + 1;
    task chk(input string nm, input [31:0] x, input [31:0] g);
        comparisons = comparisons + 1;
        if (g !== x)
        begin
            n_errors = n_errors + 1;
            $display("FAIL %0s expected %h seen %h", nm, x, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // outputs fed from the written register move one edge later
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task wait_int(input integer lim);
        integer k;
        k = 0;
        do @(posedge pclk); while (int_n !== 1'b0 && ++k < lim);
    endtask
    task t_regs;
        integer c;
        chk("int_n", 1, int_n);
        chk("iref", 1, iref);
        for (c = 0; c < 8; c = c + 1)
        begin
            apb(1, `MAS_SETUP_OFF, c | ((c & 1) << 3));
            chk("mux", c, mux);
            chk("scale", c > 4, fs);
            chk("iref", !(c & 1), iref);
        end
        for (c = 0; c < 4; c = c + 1)
        begin
            apb(1, `MAS_WAIT_OFF, (c << 4) | ((3 - c) << 6));
            chk("bias1", c, b1);
            chk("bias2", 3 - c, b2);
        end
        @(posedge pclk);
        pwr <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("bias_on", 2'b11, {th_en, a1_en});
        apb(0, 12'h020, 0);
        chk("unmapped_err", 1, e);
        chk("unmapped_data", 0, q);
        apb(0, `MAS_STAT_OFF, 0);
        chk("mask", 1, q[1]);
        apb(1, `MAS_STAT_OFF, 0);
        $display("test regs done");
    endtask
    task run_cycle(input [2:0] cnt, input [39:0] s);
        integer i, n, k;
        reg [12:0] sum;
        reg [9:0] mn, mx, v;
        n = cnt ? 4 : 1;
        sum = 0;
        mn = 10'h3FF;
        mx = 10'h000;
        apb(1, `MAS_SETUP_OFF, 0);
        apb(1, `MAS_SETUP_OFF, {cnt, 5'h10});
        for (i = 0; i < n; i = i + 1)
        begin
            v = s[i*10+:10];
            sum = sum + v;
            mn = v < mn ? v : mn;
            mx = v > mx ? v : mx;
            smp <= v;
            k = 0;
            do @(posedge pclk); while (cdone !== 1'b1 && ++k < 3000);
        end
        wait_int(100);
        chk("int_n", 0, int_n);
        for (i = 0; i < 4; i = i + 1)
        begin
            apb(1, `MAS_READ_OFF, i);
            apb(0, `MAS_READ_OFF, 0);
            chk("result", i == 0 ? sum / n : i == 1 ? mn : i == 2 ? mx : v, q[10:0]);
        end
        apb(0, `MAS_STAT_OFF, 0);
        chk("status", 0, q[0]);
        $display("test cycle of %0d done", n);
    endtask
    task t_ext;
        integer s0;
        apb(1, `MAS_SETUP_OFF, 0);
        apb(1, `MAS_DELAY_OFF, 32'h00000051);
        s0 = n_start;
        apb(1, `MAS_SETUP_OFF, 32'h00000010);
        repeat (100) @(posedge pclk);
        chk("no_start", s0, n_start);
        trig <= 1'b1;
        repeat (10) @(posedge pclk);
        trig <= 1'b0;
        repeat (1300) @(posedge pclk);
        chk("level_gone", s0, n_start);
        trig <= 1'b1;
        wait_int(1400);
        chk("ext_start", s0 + 1, n_start);
        // falling edge, no delay: pin stays high while arming
        apb(1, `MAS_SETUP_OFF, 0);
        apb(1, `MAS_DELAY_OFF, 32'h00000040);
        apb(1, `MAS_SETUP_OFF, 32'h00000010);
        s0 = n_start;
        @(posedge pclk);
        trig <= 1'b0;
        wait_int(100);
        chk("fall_start", s0 + 1, n_start);
        chk("fall_int", 0, int_n);
        $display("test external done");
    endtask
    task t_repeat;
        integer s0;
        apb(1, `MAS_SETUP_OFF, 0);
        apb(1, `MAS_DELAY_OFF, 0);
        s0 = n_start;
        apb(1, `MAS_SETUP_OFF, 32'h00000110);
        // second start one wait after the first sample, third well past the window
        repeat (800) @(posedge pclk);
        chk("repeat_starts", s0 + 2, n_start);
        chk("repeat_int", 1, int_n);
        $display("test repeat done");
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, pwr, trig, slow, paddr, pwdata, smp} = 0;
        n_errors = 0;
        comparisons = 0;
        n_start = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        run_cycle(3'h0, 40'h00000002AB);
        slow <= 1'b1;
        run_cycle(3'h1, {10'h190, 10'h0C8, 10'h12C, 10'h064});
        t_ext;
        t_repeat;
        complete_run;
    end
    // bound well above the slowest path: three waits plus the external delay
    initial
    begin
        #800000;
        n_errors = n_errors + 1;
        complete_run;
    end
endmodule // mas_sequencer_tb
